/* File: common/tpg_cfg.svh */
`ifndef TPG_CFG_SVH
`define TPG_CFG_SVH
// --------------------------------
// Register indices, byte address is four times the index
// --------------------------------
`define IDX_CTRL  10'h14A
`define IDX_ULOW  10'h14B
`define IDX_UMID  10'h14C
`define IDX_UHIGH 10'h14D
`define IDX_RES   10'h150
`define IDX_STAT  10'h151
// --------------------------------
// Fields, widths and reset values
// --------------------------------
`define CLKSEL_BIT 4
`define MODE_MSB   2
`define HIGH_MSB   3
`define CTRL_RST   8'h00
`define USER_RST   8'h00
`define RES_RST    1'b0
`define PAT_W      20
`define NARROW_W   16
`define PAD_W      12
`define RESP_OK    2'b00
`define RESP_ERR   2'b10
`endif

/* File: common/tpg_pkg.sv */
`include "tpg_cfg.svh"

package tpg_pkg;
   // Pattern select codes
   typedef enum logic [2:0] {
      PAT_OFF    = 3'h0,
      PAT_RAMP1  = 3'h1,
      PAT_RAMPU  = 3'h2,
      PAT_STATIC = 3'h4,
      PAT_TOGGLE = 3'h5
   } pat_mode_e;
   // Bus channel states, one-hot
   typedef enum logic [1:0] {
      CH_IDLE = 2'b01,
      CH_RESP = 2'b10
   } chan_state_e;
   // Register write towards the register file
   typedef struct packed {
      logic       en;
      logic [9:0] idx;
      logic [7:0] data;
   } reg_wr_s;
   // Write address and data held until paired
   typedef struct packed {
      logic       aw_held;
      logic [9:0] aw_idx;
      logic       w_held;
      logic [7:0] w_byte;
      logic       w_lane;
   } wr_hold_s;
   // Generator settings
   typedef struct packed {
      logic              clk_sel;
      logic [2:0]        mode;
      logic              res32;
      logic [`PAT_W-1:0] user;
   } gen_cfg_s;
   // Sample on the output path
   typedef struct packed {
      logic        valid;
      logic [31:0] data;
   } sample_s;

   // Codes that run the generator
   function automatic logic mode_on(input logic [2:0] m);
      return m == PAT_RAMP1 || m == PAT_RAMPU || m == PAT_STATIC || m == PAT_TOGGLE;
   endfunction : mode_on

   // Mapped register indices
   function automatic logic reg_known(input logic [9:0] i);
      return (i >= `IDX_CTRL && i <= `IDX_UHIGH) || i == `IDX_RES || i == `IDX_STAT;
   endfunction : reg_known
endpackage : tpg_pkg

/* File: logic/pattern_core.sv */
`timescale 1ns/1ps
`include "tpg_cfg.svh"

module pattern_core #(
   parameter int W = `PAT_W
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic         tick,
   input  wire logic [2:0]   mode,
   input  wire logic [W-1:0] user,
   output logic      [W-1:0] word,
   output logic              valid,
   output logic              phase
);
   logic         next_phase;
   logic         next_valid;
   logic [W-1:0] next_word;

   // Next pattern word on each selected tick
   always_comb begin
      next_word  = word;
      next_phase = phase;
      next_valid = 1'b0;
      if (!tpg_pkg::mode_on(mode)) begin
         next_word  = '0;
         next_phase = 1'b0;
      end else if (tick) begin
         next_valid = 1'b1;
         next_phase = !phase;
         case (mode)
            tpg_pkg::PAT_RAMP1: next_word = word + W'(1);
            tpg_pkg::PAT_RAMPU: next_word = word + user;
            tpg_pkg::PAT_STATIC: next_word = phase ? ~user : user;
            tpg_pkg::PAT_TOGGLE: next_word = phase ? '0 : user;
            default: next_word = word;
         endcase
      end
   end

   // Pattern state
   always_ff @(posedge clk) begin
      if (rst) begin
         word  <= '0;
         phase <= 1'b0;
         valid <= 1'b0;
      end else begin
         word  <= next_word;
         phase <= next_phase;
         valid <= next_valid;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   a_ramp_unit: assert property (
      mode == tpg_pkg::PAT_RAMP1 && tick |=> valid && word == $past(word) + W'(1))
      else $error("unit ramp step wrong");
   a_ramp_user: assert property (
      mode == tpg_pkg::PAT_RAMPU && tick |=> word == $past(word) + $past(user))
      else $error("user ramp step wrong");
   a_static_inverse: assert property (
      mode == tpg_pkg::PAT_STATIC && tick ##1 mode == tpg_pkg::PAT_STATIC && tick && $stable(user)
      |=> word == ~$past(word))
      else $error("static pattern not inverted");
   a_toggle_value: assert property (
      mode == tpg_pkg::PAT_TOGGLE && tick && !phase |=> word == $past(user) ##1 word == '0 || !$past(tick))
      else $error("toggle pattern wrong");
   a_off_clear: assert property (
      !tpg_pkg::mode_on(mode) |=> word == '0 && !valid)
      else $error("generator not idle");
   a_ramp_wrap: assert property (
      mode == tpg_pkg::PAT_RAMPU && tick && word[W-1] && user == {1'b1, {(W-1){1'b0}}}
      |=> word == {1'b0, $past(word[W-2:0])})
      else $error("ramp did not wrap");
endmodule : pattern_core

/* File: logic/axil_slave.sv */
`timescale 1ns/1ps
`include "tpg_cfg.svh"

module axil_slave (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic [11:0] awaddr,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   input  wire logic [11:0] araddr,
   input  wire logic        arvalid,
   output logic             arready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready,
   output logic [9:0]       rd_idx,
   input  wire logic [31:0] rd_word,
   output tpg_pkg::reg_wr_s wr
);
   tpg_pkg::wr_hold_s    h;
   tpg_pkg::wr_hold_s    next_h;
   tpg_pkg::chan_state_e wst;
   tpg_pkg::chan_state_e next_wst;
   tpg_pkg::chan_state_e rdst;
   tpg_pkg::chan_state_e next_rdst;
   tpg_pkg::reg_wr_s     next_wr;
   logic [1:0]           next_bresp;
   logic [1:0]           next_rresp;
   logic [31:0]          next_rdata;

   assign bvalid = wst[1];
   assign rvalid = rdst[1];
   assign rd_idx = araddr[11:2];

   // Write side: hold address and data, pair them, answer
   always_comb begin
      next_h     = h;
      next_wst   = wst;
      next_bresp = bresp;
      next_wr    = '0;
      if (awvalid && awready) begin
         next_h.aw_held = 1'b1;
         next_h.aw_idx  = awaddr[11:2];
      end
      if (wvalid && wready) begin
         next_h.w_held = 1'b1;
         next_h.w_byte = wdata[7:0];
         next_h.w_lane = wstrb[0];
      end
      case (wst)
         tpg_pkg::CH_IDLE: if (h.aw_held && h.w_held) begin
            next_wst       = tpg_pkg::CH_RESP;
            next_h.aw_held = 1'b0;
            next_h.w_held  = 1'b0;
            next_bresp     = tpg_pkg::reg_known(h.aw_idx) ? `RESP_OK : `RESP_ERR;
            next_wr.en     = h.w_lane && tpg_pkg::reg_known(h.aw_idx);
            next_wr.idx    = h.aw_idx;
            next_wr.data   = h.w_byte;
         end
         tpg_pkg::CH_RESP: if (bready) next_wst = tpg_pkg::CH_IDLE;
         default: next_wst = tpg_pkg::CH_IDLE;
      endcase
   end

   // Read side: one answer per address
   always_comb begin
      next_rdst  = rdst;
      next_rdata = rdata;
      next_rresp = rresp;
      case (rdst)
         tpg_pkg::CH_IDLE: if (arvalid && arready) begin
            next_rdst  = tpg_pkg::CH_RESP;
            next_rdata = rd_word;
            next_rresp = tpg_pkg::reg_known(rd_idx) ? `RESP_OK : `RESP_ERR;
         end
         tpg_pkg::CH_RESP: if (rready) next_rdst = tpg_pkg::CH_IDLE;
         default: next_rdst = tpg_pkg::CH_IDLE;
      endcase
   end

   // Bus state
   always_ff @(posedge clk) begin
      if (rst) begin
         h       <= '0;
         wst     <= tpg_pkg::CH_IDLE;
         rdst    <= tpg_pkg::CH_IDLE;
         bresp   <= `RESP_OK;
         rresp   <= `RESP_OK;
         rdata   <= '0;
         wr      <= '0;
         awready <= 1'b0;
         wready  <= 1'b0;
         arready <= 1'b0;
      end else begin
         h       <= next_h;
         wst     <= next_wst;
         rdst    <= next_rdst;
         bresp   <= next_bresp;
         rresp   <= next_rresp;
         rdata   <= next_rdata;
         wr      <= next_wr;
         awready <= !next_h.aw_held;
         wready  <= !next_h.w_held;
         arready <= next_rdst == tpg_pkg::CH_IDLE;
      end
   end
endmodule : axil_slave

/* File: logic/test_pattern_gen.sv */
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "tpg_cfg.svh"

module test_pattern_gen (
   input  wire logic        SYS_CLK,
   input  wire logic        RST,
   // AXI4-Lite register port
   input  wire logic [11:0] AWADDR,
   input  wire logic        AWVALID,
   output logic             AWREADY,
   input  wire logic [31:0] WDATA,
   input  wire logic [3:0]  WSTRB,
   input  wire logic        WVALID,
   output logic             WREADY,
   output logic [1:0]       BRESP,
   output logic             BVALID,
   input  wire logic        BREADY,
   input  wire logic [11:0] ARADDR,
   input  wire logic        ARVALID,
   output logic             ARREADY,
   output logic [31:0]      RDATA,
   output logic [1:0]       RRESP,
   output logic             RVALID,
   input  wire logic        RREADY,
   // Normal sample path, one strobe per output clock
   input  wire logic [31:0] SAMPLE_DATA,
   input  wire logic        SAMPLE_VALID,
   // Decimation clock strobe
   input  wire logic        DEC_TICK,
   // Towards the serializer
   output logic [31:0]      OUT_DATA,
   output logic             OUT_VALID
);
   // --------------------------------
   // Declarations
   // --------------------------------
   tpg_pkg::gen_cfg_s   cfg;
   tpg_pkg::gen_cfg_s   next_cfg;
   tpg_pkg::reg_wr_s    wr;
   tpg_pkg::sample_s    out;
   tpg_pkg::sample_s    next_out;
   logic [9:0]          rd_idx;
   logic [31:0]         rd_word;
   logic                core_tick;
   logic                core_valid;
   logic                core_phase;
   logic [`PAT_W-1:0]   core_word;

   // Reset images of the control and user bytes
   localparam logic [7:0] ctrl_init = `CTRL_RST;
   localparam logic [7:0] user_init = `USER_RST;

   // Pattern word laid out at the chosen resolution
   function automatic logic [31:0] fmt(input logic [`PAT_W-1:0] w, input logic wide);
      logic [31:0] r;
      if (wide) r = {w, {`PAD_W{1'b0}}};
      else r = {{`NARROW_W{1'b0}}, w[`PAT_W-1 -: `NARROW_W]};
      return r;
   endfunction : fmt

   // --------------------------------
   // Register bus
   // --------------------------------
   axil_slave u_bus (
      .clk     (SYS_CLK),
      .rst     (RST),
      .awaddr  (AWADDR),
      .awvalid (AWVALID),
      .awready (AWREADY),
      .wdata   (WDATA),
      .wstrb   (WSTRB),
      .wvalid  (WVALID),
      .wready  (WREADY),
      .bresp   (BRESP),
      .bvalid  (BVALID),
      .bready  (BREADY),
      .araddr  (ARADDR),
      .arvalid (ARVALID),
      .arready (ARREADY),
      .rdata   (RDATA),
      .rresp   (RRESP),
      .rvalid  (RVALID),
      .rready  (RREADY),
      .rd_idx  (rd_idx),
      .rd_word (rd_word),
      .wr      (wr)
   );

   // --------------------------------
   // Configuration registers
   // --------------------------------
   // Byte writes into the settings
   always_comb begin
      next_cfg = cfg;
      if (wr.en) begin
         case (wr.idx)
            `IDX_CTRL: begin
               next_cfg.clk_sel = wr.data[`CLKSEL_BIT];
               next_cfg.mode    = wr.data[`MODE_MSB:0];
            end
            `IDX_ULOW: next_cfg.user[7:0] = wr.data;
            `IDX_UMID: next_cfg.user[15:8] = wr.data;
            `IDX_UHIGH: next_cfg.user[`PAT_W-1:16] = wr.data[`HIGH_MSB:0];
            `IDX_RES: next_cfg.res32 = wr.data[0];
            default: next_cfg = cfg;
         endcase
      end
   end

   // Settings storage
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         cfg.clk_sel <= ctrl_init[`CLKSEL_BIT];
         cfg.mode    <= ctrl_init[`MODE_MSB:0];
         cfg.res32   <= `RES_RST;
         cfg.user    <= {user_init[`HIGH_MSB:0], user_init, user_init};
      end else begin
         cfg <= next_cfg;
      end
   end

   // Read data selected by index, reserved bits zero
   always_comb begin
      case (rd_idx)
         `IDX_CTRL: rd_word = {27'h000_0000, cfg.clk_sel, 1'b0, cfg.mode};
         `IDX_ULOW: rd_word = {24'h00_0000, cfg.user[7:0]};
         `IDX_UMID: rd_word = {24'h00_0000, cfg.user[15:8]};
         `IDX_UHIGH: rd_word = {28'h000_0000, cfg.user[`PAT_W-1:16]};
         `IDX_RES: rd_word = {31'h0000_0000, cfg.res32};
         `IDX_STAT: rd_word = {10'h000, tpg_pkg::mode_on(cfg.mode), core_phase, core_word};
         default: rd_word = 32'h0000_0000;
      endcase
   end

   // --------------------------------
   // Pattern generator
   // --------------------------------
   // pattern clock select
   assign core_tick = cfg.clk_sel ? DEC_TICK : SAMPLE_VALID;

   pattern_core #(
      .W (`PAT_W)
   ) u_core (
      .clk   (SYS_CLK),
      .rst   (RST),
      .tick  (core_tick),
      .mode  (cfg.mode),
      .user  (cfg.user),
      .word  (core_word),
      .valid (core_valid),
      .phase (core_phase)
   );

   // --------------------------------
   // Output path
   // --------------------------------
   // Pattern replaces samples while the generator runs
   always_comb begin
      next_out = out;
      if (tpg_pkg::mode_on(cfg.mode)) begin
         next_out.valid = core_valid;
         if (core_valid) next_out.data = fmt(core_word, cfg.res32);
      end else begin
         next_out.valid = SAMPLE_VALID;
         next_out.data  = SAMPLE_DATA;
      end
   end

   // Output register
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         out <= '0;
      end else begin
         out <= next_out;
      end
   end

   assign OUT_DATA  = out.data;
   assign OUT_VALID = out.valid;

   // --------------------------------
   // Checks
   // --------------------------------
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (RST);

   a_clk_sel_dec: assert property (
      tpg_pkg::mode_on(cfg.mode) && cfg.clk_sel |=> core_valid == $past(DEC_TICK))
      else $error("pattern clock select wrong");
   a_pass_through: assert property (
      !tpg_pkg::mode_on(cfg.mode)
      |=> OUT_VALID == $past(SAMPLE_VALID) && OUT_DATA == $past(SAMPLE_DATA))
      else $error("normal data altered");
   a_word_out: assert property (
      tpg_pkg::mode_on(cfg.mode) && core_valid
      |=> OUT_VALID && OUT_DATA == fmt($past(core_word), $past(cfg.res32)))
      else $error("pattern word not sent");
   a_narrow_msb: assert property (
      tpg_pkg::mode_on(cfg.mode) && core_valid && !cfg.res32
      |=> OUT_DATA[31:16] == 16'h0000 && OUT_DATA[15:0] == $past(core_word[19:4]))
      else $error("narrow output wrong");
   a_wide_pad: assert property (
      tpg_pkg::mode_on(cfg.mode) && core_valid && cfg.res32
      |=> OUT_DATA[11:0] == 12'h000 && OUT_DATA[31:12] == $past(core_word))
      else $error("wide output wrong");
   a_user_high: assert property (
      wr.en && wr.idx == `IDX_UHIGH
      |=> cfg.user[19:16] == $past(wr.data[3:0]) && $stable(cfg.user[15:0]))
      else $error("user value high nibble wrong");
   a_user_low: assert property (
      wr.en && wr.idx == `IDX_ULOW
      |=> cfg.user[7:0] == $past(wr.data) && $stable(cfg.user[`PAT_W-1:8]))
      else $error("user value low byte wrong");
   a_user_mid: assert property (
      wr.en && wr.idx == `IDX_UMID
      |=> cfg.user[15:8] == $past(wr.data) && cfg.user[7:0] == $past(cfg.user[7:0]))
      else $error("user value middle byte wrong");
   a_ctrl_write: assert property (
      wr.en && wr.idx == `IDX_CTRL
      |=> cfg.clk_sel == $past(wr.data[`CLKSEL_BIT]) && cfg.mode == $past(wr.data[`MODE_MSB:0]))
      else $error("control write wrong");
   a_tick_sample: assert property (
      tpg_pkg::mode_on(cfg.mode) && !cfg.clk_sel |=> core_valid == $past(SAMPLE_VALID))
      else $error("output clock strobe not used");
   a_core_quiet: assert property (
      !tpg_pkg::mode_on(cfg.mode) |=> !core_valid && core_word == '0)
      else $error("generator ran while off");
   a_code_idle: assert property (
      cfg.mode == 3'h6 |=> OUT_VALID == $past(SAMPLE_VALID) && OUT_DATA == $past(SAMPLE_DATA))
      else $error("code 110 altered normal data");
   a_hold_gap: assert property (
      tpg_pkg::mode_on(cfg.mode) && !core_valid |=> !OUT_VALID && $stable(OUT_DATA))
      else $error("output moved without a pattern word");
   a_res_write: assert property (
      wr.en && wr.idx == `IDX_RES |=> cfg.res32 == $past(wr.data[0]))
      else $error("resolution write wrong");
   a_one_step: assert property (
      tpg_pkg::mode_on(cfg.mode) && !core_tick |=> !core_valid && $stable(core_word))
      else $error("pattern advanced without a tick");
   a_phase_turn: assert property (
      tpg_pkg::mode_on(cfg.mode) && core_tick |=> core_phase != $past(core_phase))
      else $error("pattern phase did not turn");

   // --------------------------------
   // Bus checks
   // --------------------------------
   // control readback
   a_ctrl_read: assert property (
      ARVALID && ARREADY && ARADDR[11:2] == `IDX_CTRL
      |=> RVALID && RDATA == {27'h000_0000, $past(cfg.clk_sel), 1'b0, $past(cfg.mode)})
      else $error("control readback wrong");
   a_high_read: assert property (
      ARVALID && ARREADY && ARADDR[11:2] == `IDX_UHIGH
      |=> RVALID && RDATA == {28'h000_0000, $past(cfg.user[`PAT_W-1:16])})
      else $error("user value high readback wrong");
   // Unmapped reads answer zero
   a_read_err: assert property (
      RVALID && RRESP == `RESP_ERR |-> RDATA == 32'h0000_0000)
      else $error("unmapped read returned data");

   c_ramp_wide: cover property (
      cfg.mode == tpg_pkg::PAT_RAMP1 && cfg.res32 && core_valid ##1 OUT_VALID);
   c_dec_toggle: cover property (
      cfg.mode == tpg_pkg::PAT_TOGGLE && cfg.clk_sel && DEC_TICK ##2 OUT_VALID);
   c_static_pair: cover property (
      cfg.mode == tpg_pkg::PAT_STATIC && core_valid ##[1:8] core_valid);
   c_ramp_wrap: cover property (
      cfg.mode == tpg_pkg::PAT_RAMPU && core_valid && core_word == '0 ##1 OUT_VALID);
   c_narrow_static: cover property (
      cfg.mode == tpg_pkg::PAT_STATIC && !cfg.res32 && core_valid ##1 OUT_VALID);
endmodule : test_pattern_gen

/* File: bench/serializer_model.sv */
`timescale 1ns/1ps
// --------------------------------
// Serializer stand-in
// --------------------------------
module serializer_model (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic [31:0] data,
   input  wire logic        valid,
   output logic [31:0]      w0,
   output logic [31:0]      w1,
   output logic [31:0]      w2,
   output logic [7:0]       cnt
);
   // Shift in each presented word, no back-pressure
   always_ff @(posedge clk) begin
      if (rst) begin
         w0  <= 32'h0000_0000;
         w1  <= 32'h0000_0000;
         w2  <= 32'h0000_0000;
         cnt <= 8'h00;
      end else if (valid) begin
         w0  <= data;
         w1  <= w0;
         w2  <= w1;
         cnt <= cnt + 8'h01;
      end
   end
endmodule : serializer_model

/* File: bench/output_test_pattern_generator_tb_top.sv */
`timescale 1ns/1ps
`include "tpg_cfg.svh"

module output_test_pattern_generator_tb_top;
   // --------------------------------
   // Signals
   // --------------------------------
   logic        sys_clk, rst, awvalid, wvalid, bready, arvalid, rready;
   logic        awready, wready, bvalid, arready, rvalid, sample_valid, dec_tick, out_valid;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, sample_data, rdata, out_data, w0, w1, w2;
   logic [3:0]  wstrb, strb_mask;
   logic [1:0]  bresp, rresp;
   logic [7:0]  cnt;
   int          err_total, compares;

   // Clock generation
   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end

   test_pattern_gen dut_u (
      .SYS_CLK(sys_clk), .RST(rst), .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
      .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp),
      .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready),
      .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready), .SAMPLE_DATA(sample_data),
      .SAMPLE_VALID(sample_valid), .DEC_TICK(dec_tick), .OUT_DATA(out_data), .OUT_VALID(out_valid)
   );

   serializer_model ser_u (
      .clk(sys_clk), .rst(rst), .data(out_data), .valid(out_valid),
      .w0(w0), .w1(w1), .w2(w2), .cnt(cnt)
   );

   // --------------------------------
   // Report and compare tasks
   // --------------------------------
   task automatic complete_run;
      $display("Mismatches %0d, compares %0d", err_total, compares);
      if (err_total == 0 && compares > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : complete_run

   task automatic chk_data(input string nm, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk_data

   task automatic chk_resp(input string nm, input logic [1:0] exp, input logic [1:0] got);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR %s expected %b seen %b", nm, exp, got);
      end
   endtask : chk_resp

   // Bounded wait ran out
   task automatic hang;
      err_total++;
      $display("ERROR bus answer expected within bound seen none");
      complete_run();
   endtask : hang

   // --------------------------------
   // Register bus tasks
   // --------------------------------
   task automatic wr(input logic [9:0] idx, input logic [7:0] d, input logic [1:0] er);
      int i;
      @(posedge sys_clk);
      awaddr  <= {idx, 2'b00};
      wdata   <= {24'h00_0000, d};
      wstrb   <= strb_mask;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      for (i = 0; i < 64; i++) begin
         @(posedge sys_clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      if (i == 64) hang();
      bready <= 1'b0;
      chk_resp("bresp", er, bresp);
   endtask : wr

   task automatic rd_reg(input logic [9:0] idx, input logic [31:0] exp, input logic [1:0] er);
      int i;
      @(posedge sys_clk);
      araddr  <= {idx, 2'b00};
      arvalid <= 1'b1;
      rready  <= 1'b1;
      for (i = 0; i < 64; i++) begin
         @(posedge sys_clk);
         if (arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      if (i == 64) hang();
      rready <= 1'b0;
      chk_data("rdata", exp, rdata);
      chk_resp("rresp", er, rresp);
   endtask : rd_reg

   // Enable a pattern, give three selected ticks, each followed by an unselected strobe
   task automatic run_pat(input logic [7:0] ctrl, input logic [31:0] e0, e1, e2);
      logic [7:0] c;
      int k;
      wr(`IDX_CTRL, 8'h00, `RESP_OK);
      wr(`IDX_CTRL, ctrl, `RESP_OK);
      c = cnt;
      for (k = 0; k < 3; k++) begin
         @(posedge sys_clk);
         sample_data  <= 32'hC0DE_0000 + k[31:0];
         sample_valid <= ~ctrl[4];
         dec_tick     <= ctrl[4];
         @(posedge sys_clk);
         sample_valid <= ctrl[4];
         dec_tick     <= ~ctrl[4];
      end
      @(posedge sys_clk);
      sample_valid <= 1'b0;
      dec_tick     <= 1'b0;
      repeat (4) @(posedge sys_clk);
      chk_data("count", 32'h0000_0003, {24'h00_0000, cnt - c});
      chk_data("word0", e0, w2);
      chk_data("word1", e1, w1);
      chk_data("word2", e2, w0);
   endtask : run_pat

   // --------------------------------
   // Main sequence
   // --------------------------------
   initial begin
      int k;
      err_total = 0;
      compares = 0;
      strb_mask = 4'hF;
      rst = 1'b1;
      {awaddr, araddr, wdata, wstrb, sample_data} = '0;
      {awvalid, wvalid, bready, arvalid, rready, sample_valid, dec_tick} = '0;
      repeat (8) @(posedge sys_clk);
      rst <= 1'b0;
      // Reset values of the control and user registers
      for (k = `IDX_CTRL; k <= `IDX_UHIGH; k++) begin
         rd_reg(k[9:0], 32'h0000_0000, `RESP_OK);
      end
      rd_reg(10'h040, 32'h0000_0000, `RESP_ERR);
      wr(10'h040, 8'h5A, `RESP_ERR);
      wr(`IDX_ULOW, 8'hA5, `RESP_OK);
      wr(`IDX_UMID, 8'h3C, `RESP_OK);
      wr(`IDX_UHIGH, 8'hF7, `RESP_OK);
      rd_reg(`IDX_UHIGH, 32'h0000_0007, `RESP_OK);
      rd_reg(`IDX_UMID, 32'h0000_003C, `RESP_OK);
      // Byte lane zero off leaves the register alone
      strb_mask = 4'hE;
      wr(`IDX_ULOW, 8'h11, `RESP_OK);
      strb_mask = 4'hF;
      rd_reg(`IDX_ULOW, 32'h0000_00A5, `RESP_OK);
      run_pat(8'h00, 32'hC0DE_0000, 32'hC0DE_0001, 32'hC0DE_0002);
      run_pat(8'h06, 32'hC0DE_0000, 32'hC0DE_0001, 32'hC0DE_0002);
      wr(`IDX_RES, 8'h01, `RESP_OK);
      rd_reg(`IDX_RES, 32'h0000_0001, `RESP_OK);
      run_pat(8'h01, 32'h0000_1000, 32'h0000_2000, 32'h0000_3000);
      run_pat(8'h04, 32'h73CA_5000, 32'h8C35_A000, 32'h73CA_5000);
      run_pat(8'h05, 32'h73CA_5000, 32'h0000_0000, 32'h73CA_5000);
      wr(`IDX_RES, 8'h00, `RESP_OK);
      run_pat(8'h04, 32'h0000_73CA, 32'h0000_8C35, 32'h0000_73CA);
      wr(`IDX_ULOW, 8'h00, `RESP_OK);
      wr(`IDX_UMID, 8'h00, `RESP_OK);
      wr(`IDX_UHIGH, 8'h08, `RESP_OK);
      run_pat(8'h12, 32'h0000_8000, 32'h0000_0000, 32'h0000_8000);
      rd_reg(`IDX_CTRL, 32'h0000_0012, `RESP_OK);
      rd_reg(`IDX_STAT, 32'h0038_0000, `RESP_OK);
      complete_run();
   end
endmodule : output_test_pattern_generator_tb_top
